// ===== shared/vdxp_pkg.sv
// =====================================================
// shared constants of the dispatch and cross-path block
// =====================================================
package vdxp_pkg;
   // packet geometry
   localparam int INSN_W = 32;
   localparam int FETCH_W = 256;
   localparam int SLOTS = 8;
   localparam int UNITS = 8;
   localparam int REGS = 32;
   localparam int RA_W = 5;
   localparam int SIDES = 2;
   // instruction field positions
   localparam int CHAIN_BIT = 0;
   localparam int LONG_BIT = 1;
   localparam int UNIT_LSB = 2;
   localparam int SIZE_LSB = 5;
   localparam int STORE_BIT = 7;
   localparam int CIRC_BIT = 8;
   localparam int DSIDE_BIT = 9;
   localparam int XPATH_BIT = 12;
   localparam int SRC1_LSB = 13;
   localparam int SRC2_LSB = 18;
   localparam int DST_LSB = 23;
   localparam int ZERO_BIT = 28;
   localparam int CREG_LSB = 29;
   localparam int OFF5_LSB = 13;
   localparam int OFF15_LSB = 8;
   // special registers: long-offset base and condition registers
   localparam logic [4:0] LONG_BASE_REG = 5'h0f;
   localparam int COND_REGS = 3;
   // read ports of one side's file
   localparam int RP_SRC1 = 0;
   localparam int RP_SRC2 = 4;
   localparam int RP_XBUS = 8;
   localparam int RP_STORE = 9;
   localparam int RD_PORTS = 13;
   // reset values
   localparam logic [31:0] REG_RST = 32'h0000_0000;
   // one delay clock on a cross-path read of a fresh register
   localparam int XSTALL_CLKS = 1;
   // functional unit numbering, side a then side b
   typedef enum logic [2:0] {
      logic_unit_side_a = 3'b000,
      shift_branch_unit_side_a = 3'b001,
      multiply_unit_side_a = 3'b010,
      address_unit_side_a = 3'b011,
      logic_unit_side_b = 3'b100,
      shift_branch_unit_side_b = 3'b101,
      multiply_unit_side_b = 3'b110,
      address_unit_side_b = 3'b111
   } vdxp_unit_type;
   // memory access sizes
   typedef enum logic [1:0] {
      SZ_BYTE = 2'b00,
      SZ_HALF = 2'b01,
      SZ_WORD = 2'b10,
      SZ_DWORD = 2'b11
   } vdxp_size_type;
   // dispatcher states
   typedef enum logic [1:0] {
      ST_EMPTY = 2'b00,
      ST_READY = 2'b01,
      ST_XWAIT = 2'b10
   } vdxp_state_type;
endpackage : vdxp_pkg

// ===== hw/vdxp_regfile.sv
`timescale 1ns/100ps
// =====================================================
// one side's register file, many read ports
// =====================================================
module vdxp_regfile #(
   parameter int NRD = 13,
   parameter int NWR = 8
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   // write ports, highest index wins on a clash
   input wire logic [NWR-1:0] we_in,
   input wire logic [NWR*vdxp_pkg::RA_W-1:0] waddr_in,
   input wire logic [NWR*32-1:0] wdata_in,
   // read ports, combinational
   input wire logic [NRD*vdxp_pkg::RA_W-1:0] raddr_in,
   output logic [NRD*32-1:0] rdata_out,
   // condition registers 0..2
   output logic [vdxp_pkg::COND_REGS*32-1:0] cond_out
);
   import vdxp_pkg::*;
   logic [31:0] mem [REGS];

   // storage; packed 8/16 bit, 40 and 64 bit data live in words or even/odd pairs
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         for (int r = 0; r < REGS; r++) mem[r] <= REG_RST;
      end else if (ce_in) begin
         for (int w = 0; w < NWR; w++) begin
            if (we_in[w]) mem[waddr_in[w*RA_W +: RA_W]] <= wdata_in[w*32 +: 32];
         end
      end
   end

   // every port served in the same clock, no arbitration
   always_comb begin
      for (int p = 0; p < NRD; p++) rdata_out[p*32 +: 32] = mem[raddr_in[p*RA_W +: RA_W]];
      for (int c = 0; c < COND_REGS; c++) cond_out[c*32 +: 32] = mem[c];
   end
endmodule : vdxp_regfile

// ===== hw/vdxp_addr_gen.sv
`timescale 1ns/100ps
// =====================================================
// address unit: address, size and data side
// =====================================================
module vdxp_addr_gen #(
   parameter int CIRC_LOG = 10
) (
   // decoded instruction and base value
   input wire logic [31:0] insn_in,
   input wire logic [31:0] base_in,
   input wire logic own_side_in,
   // access description
   output logic [31:0] addr_out,
   output logic [1:0] size_out,
   output logic store_out,
   output logic dside_out
);
   import vdxp_pkg::*;
   localparam logic [31:0] CIRC_MASK = 32'((64'h1 << CIRC_LOG) - 64'h1);
   logic [31:0] off;
   logic [31:0] lin;

   // offset scaled by access size, short or long form
   always_comb begin
      size_out = insn_in[SIZE_LSB +: 2];
      store_out = insn_in[STORE_BIT];
      if (insn_in[LONG_BIT]) begin
         off = {17'h00000, insn_in[OFF15_LSB +: 15]} << size_out;
         dside_out = own_side_in;
      end else begin
         off = {27'h0000000, insn_in[OFF5_LSB +: 5]} << size_out;
         dside_out = insn_in[DSIDE_BIT];
      end
      lin = base_in + off;
      // no alignment forced: any byte address for every size
      if (!insn_in[LONG_BIT] && insn_in[CIRC_BIT]) begin
         addr_out = (base_in & ~CIRC_MASK) | (lin & CIRC_MASK);
      end else begin
         addr_out = lin;
      end
   end
endmodule : vdxp_addr_gen

// ===== hw/vdxp_dispatch.sv
`timescale 1ns/100ps
// Overview of operation
// - each clock up to eight 32-bit instructions from a 256-bit word reach units.
// - any unit may get no instruction in a cycle.
// - chaining bit in each instruction joins next one or starts new packet.
// - chaining bit is bit 0; one links next instruction, zero ends packet.
// - fetch packets are 256 bits; execute packets vary in length.
// - one execute packet per clock; next fetch only after all dispatched; a packet spilling past the buffer end lets the next fetch in before it issues.
// - execute packets may span two fetch packets without padding.
// - two sides, four units and 32x32-bit file each, 64 registers.
// - files hold packed 8/16, 32, 40 and 64-bit fixed-point operands.
// - all four units of a side read and write any own register.
// - same-side reads by all four units served in one clock.
// - one cross bus per side reads any opposite register for any unit except the address unit.
// - cross read pipelined so several units share one cross operand.
// - one delay clock when cross read hits register written last clock.
// - operands only from registers; only address units move memory data.
// - address from one side may load or store the other side's file.
// - address units do byte, half, word, doubleword in one instruction.
// - words and doublewords may start at any byte address.
// - linear modification with short or long offset; circular with short offset only.
// - every instruction conditional; some registers hold conditions.
// - packed quad 8-bit and dual 16-bit data pass through as operands.
module vdxp_dispatch #(
   parameter int CIRC_LOG = 10
) (
   // clock, reset, enable
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   // fetch packet from program memory
   input wire logic fetch_valid_in,
   input wire logic [vdxp_pkg::FETCH_W-1:0] fetch_data_in,
   output logic fetch_ready_out,
   // issue to the eight functional units
   output logic [vdxp_pkg::UNITS-1:0] unit_valid_out,
   output logic [vdxp_pkg::UNITS*32-1:0] unit_insn_out,
   output logic [vdxp_pkg::UNITS*32-1:0] unit_opnd1_out,
   output logic [vdxp_pkg::UNITS*32-1:0] unit_opnd2_out,
   output logic issue_stall_out,
   // results and load returns into the files
   input wire logic [vdxp_pkg::UNITS-1:0] res_valid_in,
   input wire logic [vdxp_pkg::UNITS-1:0] res_side_in,
   input wire logic [vdxp_pkg::UNITS*vdxp_pkg::RA_W-1:0] res_reg_in,
   input wire logic [vdxp_pkg::UNITS*32-1:0] res_data_in,
   // data memory requests, one per address unit
   output logic [1:0] mem_valid_out,
   output logic [1:0] mem_write_out,
   output logic [63:0] mem_addr_out,
   output logic [3:0] mem_size_out,
   output logic [127:0] mem_wdata_out
);
   import vdxp_pkg::*;

   // =====================================================
   // helpers
   // =====================================================
   function automatic logic is_addr_unit(input int u);
      return (u % 4) == 3;
   endfunction : is_addr_unit

   // src2 names the base register, fixed for the long-offset form
   function automatic logic [4:0] src2_of(input logic [31:0] ins, input int u);
      if (is_addr_unit(u) && ins[LONG_BIT]) return LONG_BASE_REG;
      return ins[SRC2_LSB +: RA_W];
   endfunction : src2_of

   // creg 1..3 side b regs 0..2, 4..5 side a regs 1..2, others unconditional
   function automatic logic cond_true(input logic [31:0] ins, input logic [95:0] ca,
                                      input logic [95:0] cb);
      logic [31:0] v;
      v = 32'h0000_0000;
      case (ins[CREG_LSB +: 3])
         3'h1: v = cb[31:0];
         3'h2: v = cb[63:32];
         3'h3: v = cb[95:64];
         3'h4: v = ca[63:32];
         3'h5: v = ca[95:64];
         default: return 1'b1;
      endcase
      return (v != 32'h0000_0000) ^ ins[ZERO_BIT];
   endfunction : cond_true

   // =====================================================
   // state
   // =====================================================
   vdxp_state_type state_r;
   logic [FETCH_W-1:0] buf_r;
   logic [2:0] ptr_r;
   logic [UNITS-1:0] pend_v_r;
   logic [UNITS*32-1:0] pend_i_r;
   logic [REGS-1:0] wprev_r [SIDES];

   logic [UNITS-1:0] pk_v;
   logic [UNITS*32-1:0] pk_i;
   logic done;
   logic [2:0] end_idx;
   logic [SIDES-1:0] xuse;
   logic [4:0] xaddr [SIDES];
   logic xhit;
   logic xstall;
   logic issue_go;
   logic spill;
   logic consume;
   logic [RD_PORTS*RA_W-1:0] raddr [SIDES];
   logic [RD_PORTS*32-1:0] rdata [SIDES];
   logic [95:0] cond [SIDES];
   logic [UNITS-1:0] we [SIDES];
   logic [31:0] ag_addr [2];
   logic [1:0] ag_size [2];
   logic [1:0] ag_store;
   logic [1:0] ag_dside;

   // =====================================================
   // execute packet formation from the fetch buffer
   // =====================================================
   // scan from the pointer to the first cleared chaining bit
   always_comb begin
      logic [31:0] slot;
      logic [2:0] u;
      slot = 32'h0000_0000;
      u = 3'h0;
      done = 1'b0;
      end_idx = 3'h0;
      pk_v = pend_v_r;
      pk_i = pend_i_r;
      for (int i = 0; i < SLOTS; i++) begin
         slot = buf_r[i*INSN_W +: INSN_W];
         u = slot[UNIT_LSB +: 3];
         if (state_r != ST_EMPTY && !done && 3'(i) >= ptr_r) begin
            pk_v[u] = 1'b1;
            pk_i[u*32 +: 32] = slot;
            if (!slot[CHAIN_BIT]) begin
               done = 1'b1;
               end_idx = 3'(i);
            end
         end
      end
   end

   // cross bus of each side: first unit asking for it names the register
   always_comb begin
      for (int s = 0; s < SIDES; s++) begin
         xuse[s] = 1'b0;
         xaddr[s] = 5'h00;
      end
      for (int u = 0; u < UNITS; u++) begin
         if (pk_v[u] && pk_i[u*32 + XPATH_BIT] && !is_addr_unit(u) && !xuse[u/4]) begin
            xuse[u/4] = 1'b1;
            xaddr[u/4] = pk_i[u*32 + SRC2_LSB +: RA_W];
         end
      end
      xhit = (xuse[0] && wprev_r[1][xaddr[0]]) || (xuse[1] && wprev_r[0][xaddr[1]]);
   end

   // the stall is taken once; the XWAIT state lets the packet go next clock
   assign xstall = done && state_r == ST_READY && xhit;
   assign issue_go = state_r != ST_EMPTY && done && !xstall;
   assign spill = state_r != ST_EMPTY && !done;
   assign consume = spill || (issue_go && end_idx == 3'h7);
   // ready when the buffer is empty or the whole buffer drains this clock
   assign fetch_ready_out = ce_in && (state_r == ST_EMPTY || consume);

   // =====================================================
   // dispatcher state machine
   // =====================================================
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_r <= ST_EMPTY;
         ptr_r <= 3'h0;
         buf_r <= '0;
      end else if (ce_in) begin
         case (state_r)
            ST_EMPTY: begin
               if (fetch_valid_in) begin
                  state_r <= ST_READY;
                  buf_r <= fetch_data_in;
                  ptr_r <= 3'h0;
               end
            end
            ST_READY, ST_XWAIT: begin
               if (xstall) begin
                  state_r <= ST_XWAIT;
               end else if (consume) begin
                  state_r <= fetch_valid_in ? ST_READY : ST_EMPTY;
                  if (fetch_valid_in) buf_r <= fetch_data_in;
                  ptr_r <= 3'h0;
               end else begin
                  state_r <= ST_READY;
                  ptr_r <= end_idx + 3'h1;
               end
            end
            default: state_r <= ST_EMPTY;
         endcase
      end
   end

   // partial packet carried across the fetch boundary
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pend_v_r <= '0;
         pend_i_r <= '0;
      end else if (ce_in) begin
         if (spill) begin
            pend_v_r <= pk_v;
            pend_i_r <= pk_i;
         end else if (issue_go) begin
            pend_v_r <= '0;
         end
      end
   end

   // =====================================================
   // register files and read port addressing
   // =====================================================
   // src1, src2, cross bus and store pair addresses for each file
   always_comb begin
      for (int f = 0; f < SIDES; f++) begin
         raddr[f] = '0;
         for (int u = 0; u < 4; u++) begin
            raddr[f][(RP_SRC1+u)*RA_W +: RA_W] = pk_i[(f*4+u)*32 + SRC1_LSB +: RA_W];
            raddr[f][(RP_SRC2+u)*RA_W +: RA_W] = src2_of(pk_i[(f*4+u)*32 +: 32], f*4+u);
         end
         raddr[f][RP_XBUS*RA_W +: RA_W] = xaddr[1-f];
         for (int a = 0; a < 2; a++) begin
            logic [4:0] d;
            d = pk_i[(a*4+3)*32 + DST_LSB +: RA_W];
            // doubleword stores read the even/odd pair
            if (pk_i[(a*4+3)*32 + SIZE_LSB +: 2] == SZ_DWORD) begin
               raddr[f][(RP_STORE+2*a)*RA_W +: RA_W] = {d[4:1], 1'b0};
               raddr[f][(RP_STORE+2*a+1)*RA_W +: RA_W] = {d[4:1], 1'b1};
            end else begin
               raddr[f][(RP_STORE+2*a)*RA_W +: RA_W] = d;
               raddr[f][(RP_STORE+2*a+1)*RA_W +: RA_W] = d;
            end
         end
      end
   end

   // result writes steered by their side bit, loads may cross sides
   always_comb begin
      for (int f = 0; f < SIDES; f++) begin
         for (int u = 0; u < UNITS; u++) we[f][u] = res_valid_in[u] && (res_side_in[u] == f[0]);
      end
   end

   // two files of 32 words make the 64 registers
   vdxp_regfile #(.NRD(RD_PORTS), .NWR(UNITS)) u_rf_a (
      .ref_clk_in(ref_clk_in),
      .rstn_in(rstn_in),
      .ce_in(ce_in),
      .we_in(we[0]),
      .waddr_in(res_reg_in),
      .wdata_in(res_data_in),
      .raddr_in(raddr[0]),
      .rdata_out(rdata[0]),
      .cond_out(cond[0])
   );
   vdxp_regfile #(.NRD(RD_PORTS), .NWR(UNITS)) u_rf_b (
      .ref_clk_in(ref_clk_in),
      .rstn_in(rstn_in),
      .ce_in(ce_in),
      .we_in(we[1]),
      .waddr_in(res_reg_in),
      .wdata_in(res_data_in),
      .raddr_in(raddr[1]),
      .rdata_out(rdata[1]),
      .cond_out(cond[1])
   );

   // fresh-write history for the cross-path stall check
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wprev_r[0] <= '0;
         wprev_r[1] <= '0;
      end else if (ce_in) begin
         for (int f = 0; f < SIDES; f++) begin
            wprev_r[f] <= '0;
            for (int u = 0; u < UNITS; u++) begin
               if (we[f][u]) wprev_r[f][res_reg_in[u*RA_W +: RA_W]] <= 1'b1;
            end
         end
      end
   end

   // =====================================================
   // address generation, one per address unit
   // =====================================================
   vdxp_addr_gen #(.CIRC_LOG(CIRC_LOG)) u_ag_a (
      .insn_in(pk_i[3*32 +: 32]),
      .base_in(rdata[0][(RP_SRC2+3)*32 +: 32]),
      .own_side_in(1'b0),
      .addr_out(ag_addr[0]),
      .size_out(ag_size[0]),
      .store_out(ag_store[0]),
      .dside_out(ag_dside[0])
   );
   vdxp_addr_gen #(.CIRC_LOG(CIRC_LOG)) u_ag_b (
      .insn_in(pk_i[7*32 +: 32]),
      .base_in(rdata[1][(RP_SRC2+3)*32 +: 32]),
      .own_side_in(1'b1),
      .addr_out(ag_addr[1]),
      .size_out(ag_size[1]),
      .store_out(ag_store[1]),
      .dside_out(ag_dside[1])
   );

   // =====================================================
   // issue stage registers
   // =====================================================
   // operands latched with the packet; a cross value is shared by all users
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         unit_valid_out <= '0;
         unit_insn_out <= '0;
         unit_opnd1_out <= '0;
         unit_opnd2_out <= '0;
         issue_stall_out <= 1'b0;
      end else if (ce_in) begin
         issue_stall_out <= xstall;
         for (int u = 0; u < UNITS; u++) begin
            unit_valid_out[u] <= issue_go && pk_v[u] && cond_true(pk_i[u*32 +: 32],
                                 cond[0], cond[1]);
            unit_insn_out[u*32 +: 32] <= pk_i[u*32 +: 32];
            unit_opnd1_out[u*32 +: 32] <= rdata[u/4][(RP_SRC1+u%4)*32 +: 32];
            if (pk_i[u*32 + XPATH_BIT] && !is_addr_unit(u)) begin
               unit_opnd2_out[u*32 +: 32] <= rdata[1-u/4][RP_XBUS*32 +: 32];
            end else begin
               unit_opnd2_out[u*32 +: 32] <= rdata[u/4][(RP_SRC2+u%4)*32 +: 32];
            end
         end
      end
   end

   // memory requests leave only from the address units
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         mem_valid_out <= 2'b00;
         mem_write_out <= 2'b00;
         mem_addr_out <= '0;
         mem_size_out <= '0;
         mem_wdata_out <= '0;
      end else if (ce_in) begin
         for (int a = 0; a < 2; a++) begin
            mem_valid_out[a] <= issue_go && pk_v[a*4+3] &&
                                cond_true(pk_i[(a*4+3)*32 +: 32], cond[0], cond[1]);
            mem_write_out[a] <= ag_store[a];
            mem_addr_out[a*32 +: 32] <= ag_addr[a];
            mem_size_out[a*2 +: 2] <= ag_size[a];
            mem_wdata_out[a*64 +: 32] <= rdata[ag_dside[a]][(RP_STORE+2*a)*32 +: 32];
            if (ag_size[a] == SZ_DWORD) begin
               mem_wdata_out[a*64+32 +: 32] <= rdata[ag_dside[a]][(RP_STORE+2*a+1)*32 +: 32];
            end else begin
               mem_wdata_out[a*64+32 +: 32] <= 32'h0000_0000;
            end
         end
      end
   end
endmodule : vdxp_dispatch

// ===== test/vdxp_dispatch_properties.sv
`timescale 1ns/100ps
// =====================================
// port-level checks of the dispatcher
module vdxp_dispatch_properties (
   // watched ports
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   input wire logic fetch_valid_in,
   input wire logic fetch_ready_out,
   input wire logic [7:0] unit_valid_out,
   input wire logic issue_stall_out,
   input wire logic [7:0] res_valid_in,
   input wire logic [1:0] mem_valid_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);
   // a frozen core takes nothing
   property p_frozen; !ce_in |-> !fetch_ready_out; endproperty
   a_frozen: assert property (p_frozen) else $error("ready while frozen");
   property p_answer;
      ce_in && fetch_valid_in && fetch_ready_out |-> ##[1:4] (unit_valid_out != 8'h00 || issue_stall_out);
   endproperty
   a_answer: assert property (p_answer) else $error("fetch never issued");
   // the delay clock holds the whole packet back
   property p_stall_quiet; issue_stall_out |-> unit_valid_out == 8'h00; endproperty
   a_stall_quiet: assert property (p_stall_quiet) else $error("issue in delay");
   property p_stall_then; issue_stall_out && ce_in |=> unit_valid_out != 8'h00; endproperty
   a_stall_then: assert property (p_stall_then) else $error("no issue after delay");
   property p_stall_once; issue_stall_out |=> !issue_stall_out; endproperty
   a_stall_once: assert property (p_stall_once) else $error("delay too long");
   property p_stall_cause;
      issue_stall_out |-> $past(res_valid_in, 1) != 8'h00 || $past(res_valid_in, 2) != 8'h00;
   endproperty
   a_stall_cause: assert property (p_stall_cause) else $error("delay without write");
   // memory traffic only from the address units
   property p_mem_a; mem_valid_out[0] |-> unit_valid_out[3]; endproperty
   a_mem_a: assert property (p_mem_a) else $error("memory request side a");
   property p_mem_b; mem_valid_out[1] |-> unit_valid_out[7]; endproperty
   a_mem_b: assert property (p_mem_b) else $error("memory request side b");
endmodule : vdxp_dispatch_properties
bind vdxp_dispatch vdxp_dispatch_properties vdxp_dispatch_properties_inst (
   .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .fetch_valid_in(fetch_valid_in),
   .fetch_ready_out(fetch_ready_out), .unit_valid_out(unit_valid_out),
   .issue_stall_out(issue_stall_out), .res_valid_in(res_valid_in), .mem_valid_out(mem_valid_out));

// ===== test/vdxp_prog_mem.sv
`timescale 1ns/100ps
// =====================================
// program memory: 256-bit fetch packets in order
module vdxp_prog_mem (
   // clock and enable
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   // fetch handshake
   input wire logic fetch_ready_in,
   input wire logic slow_in,
   output logic fetch_valid_out,
   output logic [255:0] fetch_data_out
);
   logic [255:0] pkt_q [$];
   logic took_r = 1'b0;
   int gap_r = 0;
   task automatic push(input logic [255:0] pkt);
      pkt_q.push_back(pkt);
   endtask : push
   initial fetch_valid_out = 1'b0;
   initial fetch_data_out = '0;
   // edge at which the core took the offer
   always @(posedge ref_clk_in) took_r <= rstn_in && ce_in && fetch_valid_out && fetch_ready_in;
   // offer held until taken; an idle bus shows a changing pattern, not stale data
   always @(negedge ref_clk_in) begin
      if (took_r) begin
         void'(pkt_q.pop_front());
         gap_r = slow_in ? 2 : 0;
      end
      if (gap_r == 0 && pkt_q.size() != 0) begin
         fetch_valid_out = 1'b1;
         fetch_data_out = pkt_q[0];
      end else begin
         gap_r = (gap_r > 0) ? gap_r - 1 : 0;
         fetch_valid_out = 1'b0;
         fetch_data_out = ~fetch_data_out;
      end
   end
endmodule : vdxp_prog_mem

// ===== test/testbench.sv
`timescale 1ns/100ps
// =====================================
// dispatcher against a queue model of packets and files
module testbench;
   import vdxp_pkg::*;
   logic ref_clk_in, rstn_in, ce_in, fvalid, fready, stall, slow;
   logic [255:0] fdata, insn, op1, op2, rdata;
   logic [7:0] uvalid, rvalid, rside;
   logic [39:0] rreg;
   logic [1:0] mvalid, mwrite;
   logic [63:0] maddr;
   logic [3:0] msize;
   logic [127:0] mwdata;
   logic [31:0] rf [2][32];
   logic [31:0] lfsr_r = 32'h0000_0062;
   logic [255:0] exp_insn [$];
   logic [7:0] exp_mask [$];
   int failures, cmp_count, exp_stall, seen_stall, cycles;
   vdxp_dispatch vdxp_dispatch_inst (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
      .fetch_valid_in(fvalid), .fetch_data_in(fdata), .fetch_ready_out(fready),
      .unit_valid_out(uvalid), .unit_insn_out(insn), .unit_opnd1_out(op1),
      .unit_opnd2_out(op2), .issue_stall_out(stall), .res_valid_in(rvalid),
      .res_side_in(rside), .res_reg_in(rreg), .res_data_in(rdata), .mem_valid_out(mvalid),
      .mem_write_out(mwrite), .mem_addr_out(maddr), .mem_size_out(msize),
      .mem_wdata_out(mwdata));
   vdxp_prog_mem vdxp_prog_mem_inst (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
      .ce_in(ce_in), .fetch_ready_in(fready), .slow_in(slow), .fetch_valid_out(fvalid),
      .fetch_data_out(fdata));
   function automatic logic [31:0] rnd();
      lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
      return lfsr_r;
   endfunction : rnd
   task automatic check_val(input logic [255:0] got, input logic [255:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : check_val
   task automatic check_count(input int got, input int exp);
      cmp_count++;
      if (got != exp) begin
         failures++;
         $display("BAD %0t count %0d want %0d", $time, got, exp);
      end
   endtask : check_count
   task automatic end_sim();
      $display("compares %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim
   // =====================================
   // stream builder: first packets 5, 6, 8 long so some cross fetch boundaries
   task automatic gen(input int npk, input bit hot);
      logic [255:0] fb, ex;
      logic [31:0] x;
      logic [7:0] m;
      logic [4:0] s2;
      int n, len, r, u;
      bit xp, anyx;
      n = 0;
      for (int k = 0; k < npk || n % 8 != 0; k++) begin
         len = (k >= npk) ? 8 - n % 8 : (k < 3) ? 5 + k + k / 2 : rnd() % 8 + 1;
         r = rnd() % 8;
         s2 = hot ? 5'h05 : 5'(rnd());
         xp = hot | rnd() % 2;
         ex = '0;
         m = '0;
         anyx = 0;
         for (int j = 0; j < len; j++) begin
            u = (r + j) % 8;
            x = rnd();
            x = {4'h0, x[27:23], s2, x[17:13], xp && u % 4 != 3, 4'h0, x[7:5], 3'(u), 1'b0,
               j < len - 1};
            anyx |= xp && u % 4 != 3;
            ex[32 * u +: 32] = x;
            m[u] = 1'b1;
            fb[32 * (n % 8) +: 32] = x;
            n++;
            if (n % 8 == 0) vdxp_prog_mem_inst.push(fb);
         end
         exp_insn.push_back(ex);
         exp_mask.push_back(m);
         exp_stall += hot && anyx;
      end
   endtask : gen
   task automatic drain();
      while (exp_mask.size() != 0) @(negedge ref_clk_in);
      repeat (4) @(negedge ref_clk_in);
   endtask : drain
   // every issue is matched against the oldest expected packet
   always @(negedge ref_clk_in) begin : mon
      logic [255:0] e;
      logic [31:0] x, ea;
      logic [7:0] m;
      int s;
      if (rstn_in && stall === 1'b1) seen_stall++;
      if (rstn_in && uvalid !== 8'h00) begin
         m = exp_mask.size() != 0 ? exp_mask.pop_front() : 8'h00;
         e = exp_insn.size() != 0 ? exp_insn.pop_front() : '0;
         check_val(uvalid, m);
         for (int u = 0; u < 8; u++) begin
            s = u / 4;
            x = e[32 * u +: 32];
            if (m[u]) check_val(insn[32 * u +: 32], x);
            if (m[u] && u % 4 != 3) begin
               check_val(op1[32 * u +: 32], rf[s][x[17:13]]);
               check_val(op2[32 * u +: 32], rf[s ^ x[12]][x[22:18]]);
            end else if (m[u]) begin
               ea = rf[s][x[22:18]] + ({27'h0, x[17:13]} << x[6:5]);
               check_val({mvalid[s], mwrite[s], msize[2 * s +: 2]}, {1'b1, x[7:5]});
               check_val(maddr[32 * s +: 32], ea);
               if (x[7]) check_val(mwdata[64 * s +: 32], rf[x[9]][{x[27:24], x[23] & ~&x[6:5]}]);
            end
         end
      end
   end
   // cut a hang short; the run needs about a hundred cycles
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         end_sim();
      end
   end
   initial begin
      ref_clk_in = 1'b0;
      forever #25 ref_clk_in = ~ref_clk_in;
   end
   initial begin
      {rstn_in, slow, rvalid, rside, rreg, rdata} = '0;
      ce_in = 1'b1;
      repeat (10) @(negedge ref_clk_in);
      rstn_in = 1'b1;
      // fill both files, eight writes a clock
      for (int c = 0; c < 8; c++) begin
         for (int u = 0; u < 8; u++) begin
            rside[u] = c / 4;
            rreg[5 * u +: 5] = 5'(c * 8 + u);
            rdata[32 * u +: 32] = rnd();
            rf[c / 4][(c * 8 + u) % 32] = rdata[32 * u +: 32];
         end
         rvalid = 8'hff;
         @(negedge ref_clk_in);
      end
      rvalid = 8'h00;
      repeat (4) @(negedge ref_clk_in);
      gen(12, 0);
      drain();
      check_count(seen_stall, 0);
      // frozen core refuses the offer; then cross reads of registers written every clock
      rside = 8'h02;
      rreg = {30'h0, 5'h05, 5'h05};
      rdata = {192'h0, rf[1][5], rf[0][5]};
      slow = 1'b1;
      gen(10, 1);
      ce_in = 1'b0;
      repeat (3) @(negedge ref_clk_in);
      check_val(fready, 1'b0);
      ce_in = 1'b1;
      rvalid = 8'h03;
      drain();
      rvalid = 8'h00;
      check_count(seen_stall, exp_stall);
      end_sim();
   end
endmodule : testbench
